// File: src/ued_pkg.sv
// Constants for the serial error-interrupt and data-port block
package ued_pkg;

  // Register offsets (byte-wide registers, 4-bit address)
  localparam logic [3:0] OFF_STATUS   = 4'h4;
  localparam logic [3:0] OFF_CTRL     = 4'h6;
  localparam logic [3:0] OFF_DATA     = 4'h7;
  localparam logic [3:0] OFF_EV_STAT  = 4'h8;
  localparam logic [3:0] OFF_EV_CLR   = 4'h9;
  localparam logic [3:0] OFF_EV_EN    = 4'hA;

  // Status register fields
  localparam int ST_TX_EMPTY = 7;
  localparam int ST_RX_FULL  = 5;
  localparam int ST_OVERRUN  = 3;
  localparam int ST_NOISE    = 2;
  localparam int ST_FRAMING  = 1;
  localparam int ST_PARITY   = 0;

  // Control register fields
  localparam int CT_RX_NINTH = 7;
  localparam int CT_TX_NINTH = 6;
  localparam int CT_NINE_BIT = 4;
  localparam int CT_OR_IE    = 3;
  localparam int CT_NF_IE    = 2;
  localparam int CT_FE_IE    = 1;
  localparam int CT_PF_IE    = 0;

  // Event register fields
  localparam int EV_RX_FULL  = 0;
  localparam int EV_TX_EMPTY = 1;
  localparam int EV_ERROR    = 2;
  localparam int EV_W        = 3;

  // Reset values
  localparam logic [7:0]      RST_BYTE   = 8'h00;
  localparam logic [3:0]      RST_IE     = 4'h0;
  localparam logic [EV_W-1:0] RST_EV     = 3'h0;
  localparam logic [8:0]      RST_WORD9  = 9'h000;

endpackage

// File: src/ued_tx_hold.sv
// Transmit data buffer holding one 9-bit character for the shifter
`timescale 1ns/1ps
module ued_tx_hold (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Load from the data port
  input  wire logic       load,
  input  wire logic [8:0] load_data,
  // Toward the transmit shifter
  input  wire logic       take,
  output logic            full,
  output logic [8:0]      data
);

  typedef struct packed {
    logic       full;
    logic [8:0] data;
  } ued_hold_t;

  ued_hold_t s_q;
  ued_hold_t s_d;

  // Load wins over take so a write in the take cycle is kept
  always_comb begin
    s_d = s_q;
    if (take) begin
      s_d.full = 1'b0;
    end
    if (load) begin
      s_d.full = 1'b1;
      s_d.data = load_data;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{full: 1'b0, data: ued_pkg::RST_WORD9};
    end else begin
      s_q <= s_d;
    end
  end

  assign full = s_q.full;
  assign data = s_q.data;

endmodule

// File: src/ued_serial_port.sv
// Serial error-interrupt enables, data port and status flag clearing
// Notes on behaviour
// R1 - overrun enable gates overrun flag onto interrupt
// R2 - noise enable, bit 2, gates noise flag
// R3 - framing enable, bit 1, gates framing flag
// R4 - parity enable, bit 0, gates parity flag
// R5 - data port at offset 7, eight bits
// R6 - data read returns receive buffer
// R7 - data write loads separate transmit buffer
// R8 - bit n maps to buffer bit n
// R9 - data accesses complete flag clearing sequences
// R10 - software reads ninth bit before data
// R11 - nine-bit value moves to shifter after write
// R12 - full buffer: set overrun, drop character
// R13 - error request is OR of gated flags
// R14 - buffers and enables reset to zero
`timescale 1ns/1ps
module ued_serial_port (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Register port
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic [7:0]      rdata,
  // From the receive shifter
  input  wire logic       rx_done,
  input  wire logic [7:0] rx_char,
  input  wire logic       rx_char_ninth,
  input  wire logic       rx_noise,
  input  wire logic       rx_framing,
  input  wire logic       rx_parity,
  // Toward the transmit shifter
  input  wire logic       tx_take,
  output logic            tx_valid,
  output logic [7:0]      tx_data,
  output logic            tx_data_ninth,
  output logic            nine_bit_mode,
  // Interrupts
  output logic            error_irq,
  output logic            irq
);

  typedef struct packed {
    logic [7:0]              rdata;
    logic [7:0]              rx_buf;
    logic                    rx_ninth_bit;
    logic                    tx_ninth_bit;
    logic                    nine_bit;
    logic                    overrun_irq_enable;
    logic                    noise_irq_enable;
    logic                    framing_irq_enable;
    logic                    parity_irq_enable;
    logic                    rx_buffer_full_flag;
    logic                    tx_empty_flag;
    logic                    overrun_flag;
    logic                    noise_flag;
    logic                    framing_error_flag;
    logic                    parity_error_flag;
    logic                    rx_armed;
    logic                    tx_armed;
    logic [ued_pkg::EV_W-1:0] ev_stat;
    logic [ued_pkg::EV_W-1:0] ev_en;
  } ued_state_t;

  ued_state_t s_q;
  ued_state_t s_d;

  logic [7:0]              status_byte;
  logic [7:0]              ctrl_byte;
  logic [7:0]              rd_mux;
  logic                    data_rd;
  logic                    data_wr;
  logic                    rx_accept;
  logic                    rx_clear;
  logic                    tx_clear;
  logic                    err_req;
  logic [ued_pkg::EV_W-1:0] ev_set;
  logic                    hold_full;
  logic [8:0]              hold_data;

  // Register images as software sees them
  always_comb begin
    status_byte = ued_pkg::RST_BYTE;
    status_byte[ued_pkg::ST_TX_EMPTY] = s_q.tx_empty_flag;
    status_byte[ued_pkg::ST_RX_FULL]  = s_q.rx_buffer_full_flag;
    status_byte[ued_pkg::ST_OVERRUN]  = s_q.overrun_flag;
    status_byte[ued_pkg::ST_NOISE]    = s_q.noise_flag;
    status_byte[ued_pkg::ST_FRAMING]  = s_q.framing_error_flag;
    status_byte[ued_pkg::ST_PARITY]   = s_q.parity_error_flag;
    ctrl_byte = ued_pkg::RST_BYTE;
    ctrl_byte[ued_pkg::CT_RX_NINTH] = s_q.rx_ninth_bit;
    ctrl_byte[ued_pkg::CT_TX_NINTH] = s_q.tx_ninth_bit;
    ctrl_byte[ued_pkg::CT_NINE_BIT] = s_q.nine_bit;
    ctrl_byte[ued_pkg::CT_OR_IE]    = s_q.overrun_irq_enable;
    ctrl_byte[ued_pkg::CT_NF_IE]    = s_q.noise_irq_enable;
    ctrl_byte[ued_pkg::CT_FE_IE]    = s_q.framing_irq_enable;
    ctrl_byte[ued_pkg::CT_PF_IE]    = s_q.parity_irq_enable;
  end

  // Read multiplexer; unmapped offsets read as zero
  always_comb begin
    case (addr)
      ued_pkg::OFF_STATUS:  rd_mux = status_byte;
      ued_pkg::OFF_CTRL:    rd_mux = ctrl_byte;
      ued_pkg::OFF_DATA:    rd_mux = s_q.rx_buf; // R6 R8
      ued_pkg::OFF_EV_STAT: rd_mux = {{(8-ued_pkg::EV_W){1'b0}}, s_q.ev_stat};
      ued_pkg::OFF_EV_EN:   rd_mux = {{(8-ued_pkg::EV_W){1'b0}}, s_q.ev_en};
      default:              rd_mux = ued_pkg::RST_BYTE;
    endcase
  end

  // Data port decode
  assign data_rd = rd && (addr == ued_pkg::OFF_DATA); // R5
  assign data_wr = wr && (addr == ued_pkg::OFF_DATA); // R5

  // Second step of each clearing sequence
  assign rx_clear = data_rd && s_q.rx_armed; // R9 R10
  assign tx_clear = data_wr && s_q.tx_armed; // R9

  // A character landing in the clearing cycle is taken, not overrun
  assign rx_accept = rx_done && (!s_q.rx_buffer_full_flag || rx_clear); // R12

  // Per-kind error gating: each flag meets only its own enable.
  // Bit order follows the control register (3 overrun, 2 noise,
  // 1 framing, 0 parity) so the enable field lines up with the flags.
  // A cleared enable leaves the flag visible to polling only.
  logic [3:0] err_flags;
  logic [3:0] err_ens;
  logic [3:0] err_gated;

  // Flags gathered in enable order
  assign err_flags[ued_pkg::CT_OR_IE] = s_q.overrun_flag;       // R1
  assign err_flags[ued_pkg::CT_NF_IE] = s_q.noise_flag;         // R2
  assign err_flags[ued_pkg::CT_FE_IE] = s_q.framing_error_flag; // R3
  assign err_flags[ued_pkg::CT_PF_IE] = s_q.parity_error_flag;  // R4

  // Enables gathered in the same order
  assign err_ens[ued_pkg::CT_OR_IE] = s_q.overrun_irq_enable; // R1
  assign err_ens[ued_pkg::CT_NF_IE] = s_q.noise_irq_enable;   // R2
  assign err_ens[ued_pkg::CT_FE_IE] = s_q.framing_irq_enable; // R3
  assign err_ens[ued_pkg::CT_PF_IE] = s_q.parity_irq_enable;  // R4

  // One AND per error kind
  for (genvar g = 0; g < 4; g++) begin : g_err_gate
    assign err_gated[g] = err_flags[g] && err_ens[g]; // R13
  end

  // Any enabled error raises the shared request; flags are registered,
  // so the request cannot glitch on bus activity
  assign err_req = |err_gated; // R1 R2 R3 R4 R13

  // Events feeding the sticky status bits
  always_comb begin
    ev_set = ued_pkg::RST_EV;
    ev_set[ued_pkg::EV_RX_FULL]  = rx_accept;
    ev_set[ued_pkg::EV_TX_EMPTY] = tx_take && hold_full;
    ev_set[ued_pkg::EV_ERROR]    = rx_done && (!rx_accept || rx_noise
                                   || rx_framing || rx_parity);
  end

  // Next-state logic for every register of the block except the transmit buffer
  always_comb begin
    s_d = s_q;
    s_d.rdata = rd ? rd_mux : ued_pkg::RST_BYTE;

    // Status read arms the data-access step of a sequence
    if (rd && addr == ued_pkg::OFF_STATUS) begin
      s_d.rx_armed = s_q.rx_buffer_full_flag || s_q.overrun_flag
                  || s_q.noise_flag || s_q.framing_error_flag
                  || s_q.parity_error_flag; // R9
      s_d.tx_armed = s_q.tx_empty_flag; // R9
    end

    // Receive side clearing, then fresh arrivals win
    if (rx_clear) begin
      s_d.rx_buffer_full_flag = 1'b0; // R9
      s_d.overrun_flag        = 1'b0;
      s_d.noise_flag          = 1'b0;
      s_d.framing_error_flag  = 1'b0;
      s_d.parity_error_flag   = 1'b0;
      s_d.rx_armed            = 1'b0;
    end
    if (rx_accept) begin
      s_d.rx_buf              = rx_char; // R8
      s_d.rx_ninth_bit        = s_q.nine_bit ? rx_char_ninth : 1'b0;
      s_d.rx_buffer_full_flag = 1'b1;
      if (rx_noise) begin
        s_d.noise_flag = 1'b1;
      end
      if (rx_framing) begin
        s_d.framing_error_flag = 1'b1;
      end
      if (rx_parity) begin
        s_d.parity_error_flag = 1'b1;
      end
    end else if (rx_done) begin
      s_d.overrun_flag = 1'b1; // R12
    end

    // Transmit side: armed data write clears empty flag, shifter take sets it
    if (tx_clear) begin
      s_d.tx_empty_flag = 1'b0; // R9
      s_d.tx_armed      = 1'b0;
    end
    if (tx_take && hold_full) begin
      s_d.tx_empty_flag = 1'b1;
    end

    // Control register write
    if (wr && addr == ued_pkg::OFF_CTRL) begin
      s_d.tx_ninth_bit       = wdata[ued_pkg::CT_TX_NINTH];
      s_d.nine_bit           = wdata[ued_pkg::CT_NINE_BIT];
      s_d.overrun_irq_enable = wdata[ued_pkg::CT_OR_IE]; // R1
      s_d.noise_irq_enable   = wdata[ued_pkg::CT_NF_IE]; // R2
      s_d.framing_irq_enable = wdata[ued_pkg::CT_FE_IE]; // R3
      s_d.parity_irq_enable  = wdata[ued_pkg::CT_PF_IE]; // R4
    end

    // Event enable and clear; a new event beats its clear
    if (wr && addr == ued_pkg::OFF_EV_EN) begin
      s_d.ev_en = wdata[ued_pkg::EV_W-1:0];
    end
    if (wr && addr == ued_pkg::OFF_EV_CLR) begin
      s_d.ev_stat = s_q.ev_stat & ~wdata[ued_pkg::EV_W-1:0];
    end
    s_d.ev_stat = s_d.ev_stat | ev_set;
  end

  // State register; enables and receive buffer come up at zero.
  // Transmit empty comes up set: nothing waits in the buffer yet,
  // so software may write the first character straight away.
  // Arming bits clear too, so a data access just after reset
  // cannot complete a clearing sequence that never started.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q.rdata               <= ued_pkg::RST_BYTE;
      s_q.rx_buf              <= ued_pkg::RST_BYTE; // R14
      s_q.rx_ninth_bit        <= 1'b0;
      s_q.tx_ninth_bit        <= 1'b0;
      s_q.nine_bit            <= 1'b0;
      s_q.overrun_irq_enable  <= 1'b0; // R14
      s_q.noise_irq_enable    <= 1'b0;
      s_q.framing_irq_enable  <= 1'b0;
      s_q.parity_irq_enable   <= 1'b0;
      s_q.rx_buffer_full_flag <= 1'b0;
      s_q.tx_empty_flag       <= 1'b1;
      s_q.overrun_flag        <= 1'b0;
      s_q.noise_flag          <= 1'b0;
      s_q.framing_error_flag  <= 1'b0;
      s_q.parity_error_flag   <= 1'b0;
      s_q.rx_armed            <= 1'b0;
      s_q.tx_armed            <= 1'b0;
      s_q.ev_stat             <= ued_pkg::RST_EV;
      s_q.ev_en               <= ued_pkg::RST_EV;
    end else begin
      s_q <= s_d;
    end
  end

  // Transmit buffer; the ninth bit is captured with the byte.
  // Software must change the ninth bit before the data write,
  // since a later change no longer reaches the buffered character.
  ued_tx_hold u_tx_hold (
    .clk       (clk),
    .rst_n     (rst_n),
    .load      (data_wr), // R7
    .load_data ({s_q.tx_ninth_bit, wdata}), // R11 R8
    .take      (tx_take),
    .full      (hold_full),
    .data      (hold_data)
  );

  // Outputs
  assign rdata         = s_q.rdata;
  assign tx_valid      = hold_full;
  assign tx_data       = hold_data[7:0];
  assign tx_data_ninth = hold_data[8];
  assign nine_bit_mode = s_q.nine_bit;
  assign error_irq     = err_req; // R13
  assign irq           = |(s_q.ev_stat & s_q.ev_en);

endmodule

// File: tb/ued_serial_port_assertions.sv
// Concurrent checks on the data port, transmit buffer and interrupt outputs
`timescale 1ns/1ps
module ued_port_chk (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  // Transmit side and interrupts
  input wire logic       tx_take,
  input wire logic       tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic       nine_bit_mode,
  input wire logic       error_irq,
  input wire logic       irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Data port write decode
  logic wd;
  assign wd = wr && addr == ued_pkg::OFF_DATA;

  a_rdata_idle: assert property (!rd |=> rdata == 8'h00)
    else $error("read data not zero outside read");
  a_reset_vals: assert property ($rose(rst_n) |-> !tx_valid && !error_irq && !irq)
    else $error("outputs not cleared by reset");
  a_tx_load: assert property (wd |=> tx_valid && tx_data == $past(wdata))
    else $error("data write did not load buffer");
  a_tx_take: assert property (tx_take && tx_valid && !wd |=> !tx_valid)
    else $error("buffer still full after take");
  a_tx_keep: assert property (tx_valid && !tx_take && !wd |=> tx_valid && $stable(tx_data))
    else $error("buffer changed without cause");
  a_mode_bit: assert property (wr && addr == ued_pkg::OFF_CTRL |=> nine_bit_mode == $past(wdata[4]))
    else $error("nine bit mode wrong");
  a_err_gate: assert property (wr && addr == ued_pkg::OFF_CTRL && wdata[3:0] == 4'h0 |=> !error_irq)
    else $error("error request with enables off");
  a_irq_gate: assert property (wr && addr == ued_pkg::OFF_EV_EN && wdata[2:0] == 3'h0 |=> !irq)
    else $error("interrupt with enables off");
endmodule

bind ued_serial_port ued_port_chk chk (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .tx_take(tx_take), .tx_valid(tx_valid), .tx_data(tx_data),
  .nine_bit_mode(nine_bit_mode), .error_irq(error_irq), .irq(irq));

// File: tb/ued_far_end.sv
// Behavioural receive and transmit shifters beside the data port
`timescale 1ns/1ps
module ued_far_end (
  // Clock
  input wire logic  clk,
  // Toward the receive buffer
  output logic       rx_done,
  output logic [7:0] rx_char,
  output logic       rx_char_ninth,
  output logic [2:0] rx_err,
  // Toward the transmit buffer
  output logic       tx_take
);
  initial begin
    {rx_done, rx_char, rx_char_ninth, rx_err, tx_take} = '0;
  end
  // Lines flip after the strobe so a stale byte is never taken as valid
  task automatic send_char(input logic [7:0] c, input logic n, input logic [2:0] e);
    @(posedge clk);
    rx_done <= 1'b1;
    rx_char <= c;
    rx_char_ninth <= n;
    rx_err <= e;
    @(posedge clk);
    rx_done <= 1'b0;
    rx_char <= ~c;
    rx_char_ninth <= ~n;
    rx_err <= 3'h0;
    #1;
  endtask
  // Slow shifter: idles a while before taking the buffer
  task automatic take(input int idle);
    repeat (idle) @(posedge clk);
    tx_take <= 1'b1;
    @(posedge clk);
    tx_take <= 1'b0;
    #1;
  endtask
endmodule

// File: tb/test_uart_error_irq_and_data_port.sv
// Self-checking bench for the serial data port block
`timescale 1ns/1ps
module test_uart_error_irq_and_data_port;
  logic       clk, rst_n, wr, rd, rx_done, rx_ninth, tx_take, tx_valid, tx_ninth;
  logic       nine_bit_mode, error_irq, irq;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, rx_char, tx_data, c1, c2;
  logic [2:0] rx_err;
  integer     seed = 3332, n_fail = 0, check_count = 0, i;

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  ued_far_end far (.clk(clk), .rx_done(rx_done), .rx_char(rx_char), .rx_char_ninth(rx_ninth),
    .rx_err(rx_err), .tx_take(tx_take));
  ued_serial_port uut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .rx_done(rx_done), .rx_char(rx_char), .rx_char_ninth(rx_ninth),
    .rx_noise(rx_err[2]), .rx_framing(rx_err[1]), .rx_parity(rx_err[0]), .tx_take(tx_take),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_data_ninth(tx_ninth),
    .nine_bit_mode(nine_bit_mode), .error_irq(error_irq), .irq(irq));

  task automatic finish_test;
    if (n_fail == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      n_fail++;
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk({1'b0, rdata}, {1'b0, e});
  endtask

  // Watchdog far beyond the hundred or so cycles needed
  initial begin
    #50000;
    n_fail++;
    finish_test;
  end
  // Main sequence
  initial begin
    {addr, wdata, wr, rd} = '0;
    rst_n = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(ued_pkg::OFF_DATA, 8'h00);
    rd_reg(ued_pkg::OFF_CTRL, 8'h00);
    rd_reg(4'hF, 8'h00);
    // Each error with its enable off, then on, then cleared
    for (i = 0; i < 4; i++) begin
      c1 = $random(seed);
      c2 = $random(seed);
      wr_reg(ued_pkg::OFF_CTRL, 8'h00);
      far.send_char(c1, 1'b0, (i < 3) ? 3'(1 << i) : 3'h0);
      if (i == 3) far.send_char(c2, 1'b0, 3'h0);
      chk({8'h00, error_irq}, 9'h000);
      wr_reg(ued_pkg::OFF_CTRL, 8'(1 << i));
      chk({8'h00, error_irq}, 9'h001);
      rd_reg(ued_pkg::OFF_STATUS, 8'hA0 | 8'(1 << i));
      rd_reg(ued_pkg::OFF_DATA, c1);
      chk({8'h00, error_irq}, 9'h000);
    end
    // Nine-bit transmit, then buffer separation
    wr_reg(ued_pkg::OFF_CTRL, 8'h50);
    chk({8'h00, nine_bit_mode}, 9'h001);
    c2 = $random(seed);
    wr_reg(ued_pkg::OFF_DATA, c2);
    chk({tx_ninth, tx_data}, {1'b1, c2});
    rd_reg(ued_pkg::OFF_DATA, c1);
    far.take(3);
    chk({8'h00, tx_valid}, 9'h000);
    far.send_char(c2, 1'b1, 3'h0);
    rd_reg(ued_pkg::OFF_CTRL, 8'hD0);
    rd_reg(ued_pkg::OFF_STATUS, 8'hA0);
    rd_reg(ued_pkg::OFF_DATA, c2);
    // Receive event raised, read, cleared and masked
    wr_reg(ued_pkg::OFF_EV_CLR, 8'h07);
    wr_reg(ued_pkg::OFF_EV_EN, 8'h01);
    far.send_char(c1, 1'b0, 3'h0);
    chk({8'h00, irq}, 9'h001);
    rd_reg(ued_pkg::OFF_EV_STAT, 8'h01);
    wr_reg(ued_pkg::OFF_EV_CLR, 8'h01);
    chk({8'h00, irq}, 9'h000);
    wr_reg(ued_pkg::OFF_EV_EN, 8'h00);
    // Reset again in mid-run: enables and status back to their start
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(ued_pkg::OFF_STATUS, 8'h80);
    rd_reg(ued_pkg::OFF_CTRL, 8'h00);
    rd_reg(ued_pkg::OFF_DATA, 8'h00);
    finish_test;
  end
endmodule
